// ---- hw/trg_random_generator.sv ----
// trg_random_generator: true random byte generator behind a classic wishbone slave.
// assumes a single 20 MHz clock, synchronous reset, and a noise bit supplied by an analog source.
`timescale 1ns/1ps
`default_nettype none

module trg_random_generator #(
  parameter int START_DELAY = trg_pkg::START_DELAY_CYC,
  parameter int RAW_BIT     = trg_pkg::RAW_BIT_CYC,
  parameter int BC_PAIR     = trg_pkg::BC_PAIR_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        noise_bit_i,
  output logic             irq_o
);
  // elaboration checks; the down-counter is only 16 bits wide
  if (START_DELAY < 1 || START_DELAY > 65535)
  begin
    $error("trg_random_generator: START_DELAY out of range");
  end
  // a zero period would wrap the reload value to 65535
  if (RAW_BIT < 1 || RAW_BIT > 65535)
  begin
    $error("trg_random_generator: RAW_BIT out of range");
  end
  if (BC_PAIR < 1 || BC_PAIR > 65535)
  begin
    $error("trg_random_generator: BC_PAIR out of range");
  end

  trg_pkg::trg_wb_req_t req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  trg_pkg::trg_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0]  shift_reg, shift_next;
  logic [2:0]  nbits_reg, nbits_next;
  logic        half_reg, half_next;
  logic        first_reg, first_next;
  logic [7:0]  value_reg;
  logic        ready_reg, int_en_reg, short_reg, bc_reg, sticky_reg, ack_reg;
  logic [31:0] rdata_reg;

  // bus decode; a request is taken on one edge, a write lands on the ack edge
  wire access    = req.cyc && req.stb && !ack_reg;
  wire commit    = req.cyc && req.stb && ack_reg;
  wire wr        = commit && req.we && req.sel[0];
  wire wbit      = req.dat[trg_pkg::FIELD_BIT];
  // address hits, shared by the write strobes and the read mux
  wire hit_start = req.adr == trg_pkg::START_TASK_OFS;
  wire hit_stop  = req.adr == trg_pkg::STOP_TASK_OFS;
  wire hit_flag  = req.adr == trg_pkg::READY_FLAG_OFS;
  wire hit_short = req.adr == trg_pkg::SHORTCUT_OFS;
  wire hit_iset  = req.adr == trg_pkg::INT_SET_OFS;
  wire hit_iclr  = req.adr == trg_pkg::INT_CLR_OFS;
  wire hit_cfg   = req.adr == trg_pkg::CONFIG_OFS;
  wire hit_out   = req.adr == trg_pkg::OUTPUT_OFS;
  wire hit_stat  = req.adr == trg_pkg::INT_STATUS_OFS;
  wire hit_sclr  = req.adr == trg_pkg::STATUS_CLR_OFS;
  // write strobes; task and set/clear registers act only on a written 1
  wire wr_start  = wr && hit_start && wbit;
  wire wr_stop   = wr && hit_stop && wbit;
  wire wr_flag   = wr && hit_flag;
  wire wr_short  = wr && hit_short;
  wire wr_iset   = wr && hit_iset && wbit;
  wire wr_iclr   = wr && hit_iclr && wbit;
  wire wr_cfg    = wr && hit_cfg;
  wire wr_sclr   = wr && hit_sclr && wbit;

  // sample timing: raw bits every RAW_BIT, corrected mode takes one sample every BC_PAIR, two per pair
  wire [15:0] period   = bc_reg ? 16'(BC_PAIR) : 16'(RAW_BIT);
  wire        tick     = (state_reg == trg_pkg::TRG_RUN) && (cnt_reg == 16'h0000);
  // pair extractor: keep first of a differing pair, drop equal pairs; length varies
  wire        bit_ok   = tick && (!bc_reg || (half_reg && first_reg != noise_bit_i));
  wire        bit_val  = bc_reg ? first_reg : noise_bit_i;
  wire        byte_done = bit_ok && nbits_reg == 3'h7;
  wire        stop_now  = wr_stop || (byte_done && short_reg);

  // shifted byte, one wire per bit; the oldest bit leaves at the top
  wire [7:0]  shifted;
  for (genvar b = 0; b < 8; b++)
  begin
    if (b == 0)
    begin
      assign shifted[b] = bit_val;
    end
    else
    begin
      assign shifted[b] = shift_reg[b - 1];
    end
  end

  // generator sequencing
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    nbits_next = nbits_reg;
    half_next  = half_reg;
    first_next = first_reg;
    unique case (state_reg)
      trg_pkg::TRG_IDLE:
      begin
        if (wr_start)
        begin
          state_next = trg_pkg::TRG_WARM;
          cnt_next   = 16'(START_DELAY - 1);
        end
      end
      trg_pkg::TRG_WARM:
      begin
        if (cnt_reg == 16'h0000)
        begin
          state_next = trg_pkg::TRG_RUN;
          cnt_next   = period - 16'h0001;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      trg_pkg::TRG_RUN:
      begin
        if (tick)
        begin
          cnt_next   = period - 16'h0001;
          half_next  = bc_reg ? !half_reg : 1'b0;
          first_next = noise_bit_i;
          if (bit_ok)
          begin
            shift_next = shifted;
            nbits_next = nbits_reg + 3'h1;
          end
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
    endcase
    // stop wins over a start in the same cycle; restart repeats warm-up
    if (stop_now)
    begin
      state_next = trg_pkg::TRG_IDLE;
      nbits_next = 3'h0;
      half_next  = 1'b0;
    end
  end

  // read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    hit_flag  ? {31'h0, ready_reg} :
    hit_short ? {31'h0, short_reg} :
    hit_iset  ? {31'h0, int_en_reg} :
    hit_iclr  ? {31'h0, int_en_reg} :
    hit_cfg   ? {31'h0, bc_reg} :
    hit_out   ? {24'h0, value_reg} :
    hit_stat  ? {31'h0, sticky_reg} : 32'h0;

  // generator state; every stop returns here, the shortcut too
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= trg_pkg::TRG_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // shared down-counter for warm-up and sample spacing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= 16'h0000;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  // byte under assembly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shift_reg <= 8'h00;
    end
    else
    begin
      shift_reg <= shift_next;
    end
  end

  // bits gathered so far; a stop throws a partial byte away
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nbits_reg <= 3'h0;
    end
    else
    begin
      nbits_reg <= nbits_next;
    end
  end

  // which sample of a pair is due
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      half_reg <= 1'b0;
    end
    else
    begin
      half_reg <= half_next;
    end
  end

  // first sample of the current pair
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      first_reg <= 1'b0;
    end
    else
    begin
      first_reg <= first_next;
    end
  end

  // held byte; the next one overwrites it without waiting for a read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      value_reg <= trg_pkg::VALUE_RESET;
    end
    else if (byte_done)
    begin
      value_reg <= shifted;
    end
  end

  // ready flag; a byte event wins over a software write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ready_reg <= 1'b0;
    end
    else if (byte_done)
    begin
      ready_reg <= 1'b1;
    end
    else if (wr_flag)
    begin
      ready_reg <= wbit;
    end
  end

  // sticky status; set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sticky_reg <= 1'b0;
    end
    else if (byte_done)
    begin
      sticky_reg <= 1'b1;
    end
    else if (wr_sclr)
    begin
      sticky_reg <= 1'b0;
    end
  end

  // interrupt enable; set and clear never meet, one access at a time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      int_en_reg <= 1'b0;
    end
    else if (wr_iset)
    begin
      int_en_reg <= 1'b1;
    end
    else if (wr_iclr)
    begin
      int_en_reg <= 1'b0;
    end
  end

  // ready-to-stop shortcut
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      short_reg <= 1'b0;
    end
    else if (wr_short)
    begin
      short_reg <= wbit;
    end
  end

  // bias correction enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bc_reg <= 1'b0;
    end
    else if (wr_cfg)
    begin
      bc_reg <= wbit;
    end
  end

  // bus answer: ack one cycle after the taking edge, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= access;
    end
  end

  // read data stands with ack only, zero otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= 32'h0;
    end
    else
    begin
      rdata_reg <= access ? rd_mux : 32'h0;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  // line follows the ready flag only; the sticky status is for polling
  assign irq_o    = int_en_reg && ready_reg;
endmodule

`default_nettype wire

// ---- hw/trg_pkg.sv ----
// trg_pkg: register map, field layout, reset values and timing for the random byte generator.
// assumes a 32-bit classic wishbone slave; byte addresses are the printed offsets.
package trg_pkg;
  localparam logic [11:0] START_TASK_OFS   = 12'h000;
  localparam logic [11:0] STOP_TASK_OFS    = 12'h004;
  localparam logic [11:0] READY_FLAG_OFS   = 12'h100;
  localparam logic [11:0] SHORTCUT_OFS     = 12'h200;
  localparam logic [11:0] INT_SET_OFS      = 12'h304;
  localparam logic [11:0] INT_CLR_OFS      = 12'h308;
  localparam logic [11:0] CONFIG_OFS       = 12'h504;
  localparam logic [11:0] OUTPUT_OFS       = 12'h508;
  localparam logic [11:0] INT_STATUS_OFS   = 12'h600;
  localparam logic [11:0] STATUS_CLR_OFS   = 12'h604;
  localparam int          FIELD_BIT        = 0;
  localparam logic [7:0]  VALUE_RESET      = 8'h00;
  localparam int          CLK_HZ           = 20000000;
  localparam int          START_DELAY_US   = 128;
  localparam int          RAW_BYTE_US      = 30;
  localparam int          BC_BYTE_US       = 120;
  localparam int          START_DELAY_CYC  = (START_DELAY_US * (CLK_HZ / 1000000));
  localparam int          RAW_BIT_CYC      = (RAW_BYTE_US * (CLK_HZ / 1000000)) / 8;
  localparam int          BC_PAIR_CYC      = (BC_BYTE_US * (CLK_HZ / 1000000)) / 32;

  typedef enum logic [2:0] {
    TRG_IDLE  = 3'b001,
    TRG_WARM  = 3'b010,
    TRG_RUN   = 3'b100
  } trg_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } trg_wb_req_t;
endpackage

// ---- tb/trg_random_generator_properties.sv ----
// trg_props: port-level bus and interrupt checks for the generator.
// assumes a bind onto trg_random_generator and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module trg_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // read answer while the master still holds the address
  sequence rd_ack(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  chk_ack_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack unasked");
  chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
  chk_value_upper: assert property (rd_ack(12'h508) |-> wb_dat_o[31:8] == 24'h0)
    else $error("value upper bits");
  chk_flag_width: assert property (rd_ack(12'h100) |-> wb_dat_o[31:1] == 31'h0)
    else $error("flag upper bits");
  chk_hole_zero: assert property (rd_ack(12'h010) |-> wb_dat_o == 32'h0) else $error("hole read");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("irq dropped unasked");
endmodule
`default_nettype wire

// ---- tb/trg_random_generator_tb.sv ----
// trg_random_generator_tb: register-level scenarios for the generator.
// assumes the checker file is compiled first; counts shortened.
`timescale 1ns/1ps
`default_nettype none
module trg_random_generator_tb;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 noise = 1'b1;
  logic                 lvl = 1'b1;
  logic                 tog = 1'b0;
  logic                 ph = 1'b0;
  logic [31:0]          q;
  int                   err_total = 0;
  int                   samples_checked = 0;
  trg_pkg::trg_wb_req_t rq = '0;
  wire logic [31:0]     dat_o;
  wire logic            ack_o;
  wire logic            irq_o;
  trg_random_generator #(.START_DELAY(4), .RAW_BIT(2), .BC_PAIR(2)) trg_random_generator_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(rq.cyc), .wb_stb_i(rq.stb), .wb_we_i(rq.we),
    .wb_adr_i(rq.adr), .wb_sel_i(rq.sel), .wb_dat_i(rq.dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack_o), .noise_bit_i(noise), .irq_o(irq_o));
  // clock, watchdog, and noise held at lvl, or toggled under tog so its sample pairs differ
  initial forever #25 clk_i = ~clk_i;
  initial
  begin
    #2000000;
    err_total++;
    final_report();
  end
  always @(posedge clk_i)
  begin
    ph <= ~ph;
    if (tog && ph)
      noise <= ~noise;
    else if (!tog)
      noise <= lvl;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    rq <= '0;
  endtask
  // bounded wait; the line must end at level e
  task automatic wait_irq(input logic e, input int lim);
    int n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (irq_o !== 1'b1 && n < lim);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
  endtask
  // clear the flag and the sticky status; only the flag holds the line up
  task automatic clr_ev();
    wb(1'b1, 12'h100, 32'h0);
    wb(1'b1, 12'h604, 32'h1);
  endtask
  task automatic t_reset();
    logic [11:0] ofs[7] = '{12'h100, 12'h200, 12'h304, 12'h308, 12'h504, 12'h508, 12'h600};
    foreach (ofs[i])
    begin
      wb(1'b0, ofs[i], 32'h0);
      chk("reset", 32'h0, q);
    end
  endtask
  task automatic t_enable();
    wb(1'b1, 12'h304, 32'h1);
    wb(1'b0, 12'h308, 32'h0);
    chk("en", 32'h1, q);
    wb(1'b1, 12'h308, 32'h0);
    wb(1'b0, 12'h304, 32'h0);
    chk("en", 32'h1, q);
    wb(1'b1, 12'h308, 32'h1);
    wb(1'b0, 12'h304, 32'h0);
    chk("en", 32'h0, q);
    wb(1'b1, 12'h304, 32'h0);
    wb(1'b0, 12'h308, 32'h0);
    chk("en", 32'h0, q);
    wb(1'b1, 12'h304, 32'h1);
  endtask
  task automatic t_run();
    wb(1'b1, 12'h000, 32'h1);
    wait_irq(1'b1, 200);
    wb(1'b0, 12'h508, 32'h0);
    chk("value", 32'hFF, q);
    wb(1'b1, 12'h004, 32'h1);
    wb(1'b1, 12'h308, 32'h1);
    @(posedge clk_i);
    chk("masked", 32'h0, {31'h0, irq_o});
    wb(1'b1, 12'h304, 32'h1);
    wb(1'b0, 12'h100, 32'h0);
    chk("flag", 32'h1, q);
    wb(1'b0, 12'h600, 32'h0);
    chk("status", 32'h1, q);
    wb(1'b1, 12'h100, 32'h0);
    wait_irq(1'b0, 2);
    wb(1'b1, 12'h604, 32'h1);
    wait_irq(1'b0, 100);
    wb(1'b1, 12'h000, 32'h1);
    wait_irq(1'b1, 200);
    clr_ev();
    wait_irq(1'b1, 40);
    wb(1'b1, 12'h004, 32'h1);
    clr_ev();
  endtask
  task automatic t_short();
    lvl <= 1'b0;
    wb(1'b1, 12'h200, 32'h1);
    wb(1'b1, 12'h000, 32'h1);
    wait_irq(1'b1, 200);
    clr_ev();
    wait_irq(1'b0, 100);
    wb(1'b1, 12'h508, 32'h55);
    wb(1'b0, 12'h508, 32'h0);
    chk("value", 32'h0, q);
    wb(1'b1, 12'h010, 32'h1);
    wb(1'b0, 12'h010, 32'h0);
    chk("hole", 32'h0, q);
    wb(1'b1, 12'h200, 32'h0);
  endtask
  // constant noise gives only equal pairs, so no byte at all
  task automatic t_bias();
    wb(1'b1, 12'h504, 32'h1);
    wb(1'b1, 12'h000, 32'h1);
    wait_irq(1'b0, 300);
    tog <= 1'b1;
    wait_irq(1'b1, 500);
    wb(1'b0, 12'h508, 32'h0);
    chk("bc value", 32'h1, {31'h0, q === 32'hFF || q === 32'h0});
    wb(1'b1, 12'h004, 32'h1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_enable();
    t_run();
    t_short();
    t_bias();
    final_report();
  end
endmodule
bind trg_random_generator trg_props trg_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire
